// file: rtl/iaas_pkg.sv
// Package for the isolated acquisition sequencer: register map, fields,
// reset values, timing counts and state type.
// Assumes a single 20 MHz core clock and a 32-bit Avalon-MM register bus.
package iaas_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int CONV_TIME_NS = 10_000;
    localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILT_TIME_NS = 1_000;
    localparam int FILT_CYCLES = (FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILT_W = $clog2(FILT_CYCLES + 1);
    localparam int CONV_W = $clog2(CONV_CYCLES + 1);

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_CH = 16;
    localparam int SAMPLE_W = 16;
    localparam int BUF_DEPTH = 1024;
    localparam int ADDR_W = 5;
    localparam int NUM_EXT = 3;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_CTRL = 5'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 5'h04;
    localparam logic [ADDR_W-1:0] REG_INTERVAL = 5'h08;
    localparam logic [ADDR_W-1:0] REG_COUNT = 5'h0C;
    localparam logic [ADDR_W-1:0] REG_DATA = 5'h10;
    localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 5'h14;
    localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 5'h18;
    localparam logic [ADDR_W-1:0] REG_CAL = 5'h1C;

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    localparam int CTRL_START = 0;
    localparam int CTRL_STOP = 1;
    localparam int CTRL_START_EXT = 2;
    localparam int CTRL_STOP_SRC = 3;
    localparam int CTRL_CLK_EXT = 5;
    localparam int CTRL_FALL = 6;
    localparam int CTRL_FILT = 9;
    localparam int CTRL_CAL_USER = 12;
    localparam int CTRL_LAST_CH = 16;
    localparam logic [31:0] CTRL_KEEP = 32'h000F_1FFC;
    localparam logic [1:0] STOP_COUNT = 2'h0;
    localparam logic [1:0] STOP_EXT = 2'h1;

    // ------------------------------------------------------------
    // Interrupt bits and external input indices
    // ------------------------------------------------------------
    localparam int IRQ_W = 4;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_OVF = 1;
    localparam int IRQ_OVERRUN = 2;
    localparam int IRQ_SCAN = 3;
    localparam int EXT_START = 0;
    localparam int EXT_STOP = 1;
    localparam int EXT_CLK = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] INTERVAL_RST = 32'h0000_0C80;
    localparam logic [31:0] COUNT_RST = 32'h0000_0001;
    localparam logic [IRQ_W-1:0] MASK_RST = 4'h0;
    localparam logic [15:0] CAL_RST = 16'h0000;

    typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_RUN, ST_CONV} iaas_state_type;

endpackage

// file: rtl/iaas_trig_if.sv
// Interface joining the sequencer core to its external input conditioner.
// Assumes both ends run on core_clk.
`timescale 1ns/1ps
interface iaas_trig_if;
    logic [2:0] filtEn;
    logic [2:0] fallSel;
    logic [2:0] edgePulse;

    modport core (output filtEn, output fallSel, input edgePulse);
    modport cond (input filtEn, input fallSel, output edgePulse);
endinterface

// file: rtl/iaas_input_cond.sv
// Synchroniser, 1 us glitch filter and edge selector for the external
// start, stop and sampling clock pins.
// Assumes the pins are asynchronous to core_clk.
`timescale 1ns/1ps
module iaas_input_cond
    import iaas_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Raw pins
    input wire logic [2:0] extPin,
    // Core side
    iaas_trig_if.cond trig
);
    logic [2:0] sync1_ff, sync2_ff, filt_ff, prev_ff;
    logic [2:0] nxt_filt;
    logic [FILT_W-1:0] cnt_ff [3];
    logic [FILT_W-1:0] nxt_cnt [3];

    // Filter: a new level is taken only after it held FILT_CYCLES cycles
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            nxt_filt[i] = filt_ff[i];
            nxt_cnt[i] = '0;
            if (!trig.filtEn[i]) begin
                nxt_filt[i] = sync2_ff[i];
            end else if (sync2_ff[i] != filt_ff[i]) begin
                if (cnt_ff[i] == FILT_W'(FILT_CYCLES - 1)) begin
                    nxt_filt[i] = sync2_ff[i];
                end else begin
                    nxt_cnt[i] = cnt_ff[i] + FILT_W'(1);
                end
            end
        end
    end

    // Registers
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            filt_ff <= '0;
            prev_ff <= '0;
            for (int i = 0; i < 3; i++) begin
                cnt_ff[i] <= '0;
            end
        end else begin
            sync1_ff <= extPin;
            sync2_ff <= sync1_ff;
            filt_ff <= nxt_filt;
            prev_ff <= filt_ff;
            for (int i = 0; i < 3; i++) begin
                cnt_ff[i] <= nxt_cnt[i];
            end
        end
    end

    // Edge of the chosen polarity on the filtered level
    assign trig.edgePulse = (filt_ff ^ prev_ff) & (filt_ff ^ trig.fallSel);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_EDGE_POL: assert property (@(posedge core_clk) disable iff (sys_rst)
        trig.edgePulse[0] |-> (filt_ff[0] == !trig.fallSel[0]) && $past(filt_ff[0]) != filt_ff[0])
        else $error("start edge of wrong polarity");
    AST_FILT_HOLD: assert property (@(posedge core_clk) disable iff (sys_rst)
        $changed(filt_ff[0]) && $past(trig.filtEn[0])
        |-> $past(cnt_ff[0]) == FILT_W'(FILT_CYCLES - 1))
        else $error("start level passed filter too early");
endmodule

// file: rtl/iaas_sequencer.sv
// Acquisition sequencer for a 16 channel, 16 bit converter: trigger and
// stop selection, pacing, 1k sample buffer, interrupts, Avalon-MM slave.
// Assumes the converter result is valid on adcData one conversion time
// after adcStart, on the same clock.
//
// Our own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module iaas_sequencer
    import iaas_pkg::*;
#(
    parameter int BUF_D = BUF_DEPTH,
    parameter logic [15:0] FACTORY_OFFSET = 16'h0000
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Avalon-MM slave
    input wire logic [iaas_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // External control pins
    input wire logic extStartPin,
    input wire logic extStopPin,
    input wire logic extClkPin,
    // Converter
    output logic adcStart,
    output logic [3:0] adcChan,
    input wire logic [iaas_pkg::SAMPLE_W-1:0] adcData,
    // Interrupt
    output logic irqOut
);
    localparam int PTR_W = $clog2(BUF_D);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    iaas_trig_if trig ();
    logic resp_ff, nxt_resp;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [31:0] ctrl_ff, nxt_ctrl, interval_ff, nxt_interval, count_ff, nxt_count;
    logic [IRQ_W-1:0] mask_ff, nxt_mask, irq_ff, nxt_irq, irqSet, irqClr;
    logic [15:0] cal_ff, nxt_cal;
    logic [31:0] calWord;
    iaas_state_type state_ff, nxt_state;
    logic [3:0] chan_ff, nxt_chan;
    logic [CONV_W-1:0] conv_ff, nxt_conv;
    logic [31:0] timer_ff, nxt_timer, scans_ff, nxt_scans;
    logic stopPend_ff, nxt_stopPend, adcStart_ff, nxt_adcStart;
    logic [PTR_W-1:0] wrPtr_ff, nxt_wrPtr, rdPtr_ff, nxt_rdPtr;
    logic [PTR_W:0] fill_ff, nxt_fill;
    logic [SAMPLE_W-1:0] mem [BUF_D];
    logic memWe;
    logic [SAMPLE_W-1:0] sample;
    logic busReq, busWr, busRd, startCmd, stopCmd, stopReq, scanTrig, pop, full, empty;
    logic [1:0] stopSrc;
    logic [3:0] lastCh;

    // Byte-lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // External input conditioning
    // ------------------------------------------------------------
    iaas_input_cond u_cond (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .extPin({extClkPin, extStopPin, extStartPin}),
        .trig(trig.cond)
    );
    assign trig.fallSel = ctrl_ff[CTRL_FALL +: 3];
    assign trig.filtEn = ctrl_ff[CTRL_FILT +: 3];

    // ------------------------------------------------------------
    // Bus slave: one wait cycle, effect at the accepting edge
    // ------------------------------------------------------------
    assign busReq = avs_read | avs_write;
    assign avs_waitrequest = busReq & ~resp_ff;
    assign busWr = avs_write & resp_ff;
    assign busRd = avs_read & resp_ff;
    assign avs_readdata = rdata_ff;
    assign startCmd = busWr && avs_address == REG_CTRL && avs_byteenable[0]
                      && avs_writedata[CTRL_START];
    assign stopCmd = busWr && avs_address == REG_CTRL && avs_byteenable[0]
                     && avs_writedata[CTRL_STOP];
    assign irqClr = (busWr && avs_address == REG_IRQ_STAT && avs_byteenable[0])
                    ? avs_writedata[IRQ_W-1:0] : '0;
    assign pop = busRd && avs_address == REG_DATA && !empty;

    // Register file next values and read mux
    always_comb begin
        nxt_resp = busReq & ~resp_ff;
        nxt_rdata = rdata_ff;
        nxt_ctrl = ctrl_ff;
        nxt_interval = interval_ff;
        nxt_count = count_ff;
        nxt_mask = mask_ff;
        nxt_cal = cal_ff;
        calWord = merge({16'h0000, cal_ff}, avs_writedata, avs_byteenable);
        if (busReq && !resp_ff) begin
            unique case (avs_address)
                REG_CTRL: nxt_rdata = ctrl_ff;
                REG_STATUS: nxt_rdata = {5'h00, fill_ff, 12'h000, full, empty,
                                         state_ff == ST_ARM, state_ff != ST_IDLE};
                REG_INTERVAL: nxt_rdata = interval_ff;
                REG_COUNT: nxt_rdata = count_ff;
                REG_DATA: nxt_rdata = empty ? 32'h0000_0000 : {16'h0000, mem[rdPtr_ff]};
                REG_IRQ_STAT: nxt_rdata = {28'h000_0000, irq_ff};
                REG_IRQ_MASK: nxt_rdata = {28'h000_0000, mask_ff};
                REG_CAL: nxt_rdata = {16'h0000, cal_ff};
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
        if (busWr) begin
            unique case (avs_address)
                REG_CTRL: nxt_ctrl = merge(ctrl_ff, avs_writedata, avs_byteenable) & CTRL_KEEP;
                REG_INTERVAL: nxt_interval = merge(interval_ff, avs_writedata, avs_byteenable);
                REG_COUNT: nxt_count = merge(count_ff, avs_writedata, avs_byteenable);
                REG_IRQ_MASK: begin
                    if (avs_byteenable[0]) begin
                        nxt_mask = avs_writedata[IRQ_W-1:0];
                    end
                end
                REG_CAL: nxt_cal = calWord[15:0];
                default: ;
            endcase
        end
    end

    // Register file storage
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            resp_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            ctrl_ff <= CTRL_RST;
            interval_ff <= INTERVAL_RST;
            count_ff <= COUNT_RST;
            mask_ff <= MASK_RST;
            cal_ff <= CAL_RST;
        end else begin
            resp_ff <= nxt_resp;
            rdata_ff <= nxt_rdata;
            ctrl_ff <= nxt_ctrl;
            interval_ff <= nxt_interval;
            count_ff <= nxt_count;
            mask_ff <= nxt_mask;
            cal_ff <= nxt_cal;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    assign stopSrc = ctrl_ff[CTRL_STOP_SRC +: 2];
    assign lastCh = ctrl_ff[CTRL_LAST_CH +: 4];
    assign full = fill_ff == (PTR_W+1)'(BUF_D);
    assign empty = fill_ff == '0;
    // Software stop ends the run in any stop mode, after the scan in progress
    assign stopReq = stopCmd | (stopSrc == STOP_EXT && trig.edgePulse[EXT_STOP]);
    assign scanTrig = ctrl_ff[CTRL_CLK_EXT] ? trig.edgePulse[EXT_CLK]
                      : timer_ff == 32'h0000_0000;
    // Selected calibration offset applied to the raw result
    assign sample = adcData + (ctrl_ff[CTRL_CAL_USER] ? cal_ff : FACTORY_OFFSET);

    // Sequencer next state, buffer pointers and interrupt status
    always_comb begin
        nxt_state = state_ff;
        nxt_chan = chan_ff;
        nxt_conv = conv_ff;
        nxt_timer = timer_ff;
        nxt_scans = scans_ff;
        nxt_stopPend = stopPend_ff;
        nxt_adcStart = 1'b0;
        nxt_wrPtr = wrPtr_ff;
        irqSet = '0;
        memWe = 1'b0;
        // Interval timer reloads at each expiry in ST_RUN and ST_CONV
        if (state_ff == ST_RUN || state_ff == ST_CONV) begin
            nxt_timer = (timer_ff == 32'h0000_0000) ? interval_ff - 32'h0000_0001
                        : timer_ff - 32'h0000_0001;
        end
        unique case (state_ff)
            ST_IDLE: begin
                nxt_timer = 32'h0000_0000;
                nxt_scans = 32'h0000_0000;
                nxt_stopPend = 1'b0;
                // Start source travels with the command write itself
                if (startCmd) begin
                    nxt_state = avs_writedata[CTRL_START_EXT] ? ST_ARM : ST_RUN;
                end
            end
            ST_ARM: begin
                if (stopReq) begin
                    nxt_state = ST_IDLE;
                    irqSet[IRQ_DONE] = 1'b1;
                end else if (trig.edgePulse[EXT_START]) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (stopReq || stopPend_ff) begin
                    nxt_state = ST_IDLE;
                    irqSet[IRQ_DONE] = 1'b1;
                end else if (scanTrig) begin
                    nxt_state = ST_CONV;
                    nxt_chan = 4'h0;
                    nxt_conv = CONV_W'(CONV_CYCLES - 1);
                    nxt_adcStart = 1'b1;
                end
            end
            ST_CONV: begin
                if (scanTrig) begin
                    irqSet[IRQ_OVERRUN] = 1'b1;
                end
                if (stopReq) begin
                    nxt_stopPend = 1'b1;
                end
                if (conv_ff == '0) begin
                    // Store result, drop it if the buffer is full and not popped this cycle
                    if (full && !pop) begin
                        irqSet[IRQ_OVF] = 1'b1;
                    end else begin
                        memWe = 1'b1;
                        nxt_wrPtr = wrPtr_ff + PTR_W'(1);
                    end
                    if (chan_ff == lastCh) begin
                        nxt_scans = scans_ff + 32'h0000_0001;
                        irqSet[IRQ_SCAN] = 1'b1;
                        nxt_state = ST_RUN;
                        if ((stopSrc == STOP_COUNT && nxt_scans == count_ff)
                            || stopReq || stopPend_ff) begin
                            nxt_state = ST_IDLE;
                            irqSet[IRQ_DONE] = 1'b1;
                        end
                    end else begin
                        nxt_chan = chan_ff + 4'h1;
                        nxt_conv = CONV_W'(CONV_CYCLES - 1);
                        nxt_adcStart = 1'b1;
                    end
                end else begin
                    nxt_conv = conv_ff - CONV_W'(1);
                end
            end
        endcase
        nxt_rdPtr = pop ? rdPtr_ff + PTR_W'(1) : rdPtr_ff;
        nxt_fill = fill_ff + (PTR_W+1)'(memWe) - (PTR_W+1)'(pop);
        // Hardware set wins over software clear
        nxt_irq = (irq_ff & ~irqClr) | irqSet;
    end

    // Sequencer registers
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_ff <= ST_IDLE;
            chan_ff <= 4'h0;
            conv_ff <= '0;
            timer_ff <= 32'h0000_0000;
            scans_ff <= 32'h0000_0000;
            stopPend_ff <= 1'b0;
            adcStart_ff <= 1'b0;
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            fill_ff <= '0;
            irq_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            chan_ff <= nxt_chan;
            conv_ff <= nxt_conv;
            timer_ff <= nxt_timer;
            scans_ff <= nxt_scans;
            stopPend_ff <= nxt_stopPend;
            adcStart_ff <= nxt_adcStart;
            wrPtr_ff <= nxt_wrPtr;
            rdPtr_ff <= nxt_rdPtr;
            fill_ff <= nxt_fill;
            irq_ff <= nxt_irq;
        end
    end

    // Sample buffer storage
    always_ff @(posedge core_clk) begin
        if (memWe) begin
            mem[wrPtr_ff] <= sample;
        end
    end

    // Outputs
    assign adcStart = adcStart_ff;
    assign adcChan = chan_ff;
    assign irqOut = |(irq_ff & mask_ff);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [CONV_W-1:0] gap_ff;
    logic seenStart_ff;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            gap_ff <= '0;
            seenStart_ff <= 1'b0;
        end else begin
            gap_ff <= adcStart_ff ? CONV_W'(1)
                      : (gap_ff == CONV_W'(CONV_CYCLES) ? gap_ff : gap_ff + CONV_W'(1));
            seenStart_ff <= seenStart_ff | adcStart_ff;
        end
    end
    sequence s_swStart;
        state_ff == ST_IDLE && startCmd && !avs_writedata[CTRL_START_EXT];
    endsequence
    sequence s_extPace;
        state_ff == ST_RUN && ctrl_ff[CTRL_CLK_EXT] && trig.edgePulse[EXT_CLK]
        && !stopReq && !stopPend_ff;
    endsequence

    AST_CHAN_RANGE: assert property (@(posedge core_clk) disable iff (sys_rst)
        adcStart |-> adcChan <= lastCh)
        else $error("channel beyond scan range");
    AST_CONV_GAP: assert property (@(posedge core_clk) disable iff (sys_rst)
        adcStart && seenStart_ff |-> gap_ff == CONV_W'(CONV_CYCLES))
        else $error("conversions closer than one conversion time");
    AST_PUSH: assert property (@(posedge core_clk) disable iff (sys_rst)
        memWe && !pop |=> fill_ff == $past(fill_ff) + (PTR_W+1)'(1))
        else $error("stored sample not counted");
    AST_SW_START: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_swStart |=> state_ff == ST_RUN)
        else $error("software start ignored");
    AST_ARM_STOP: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_ff == ST_ARM && stopReq |=> state_ff == ST_IDLE ##0 irq_ff[IRQ_DONE])
        else $error("stop while armed not honoured");
    AST_EXT_PACE: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_extPace |=> adcStart && adcChan == 4'h0)
        else $error("external clock edge did not start a scan");
    AST_OVF_FLAG: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_ff == ST_CONV && conv_ff == '0 && full && !pop |=> irq_ff[IRQ_OVF] && !memWe)
        else $error("overflow not flagged");
    AST_IRQ_LINE: assert property (@(posedge core_clk) disable iff (sys_rst)
        irqSet[IRQ_DONE] && mask_ff[IRQ_DONE] && $stable(mask_ff) |=> irqOut [*1])
        else $error("masked-in event did not raise interrupt");
endmodule

// file: testbench/iaas_adc_model.sv
// Behavioural converter on the far side of the sequencer.
// Assumes one core_clk; a result is valid only near its sampling edge.
`timescale 1ns/1ps
module iaas_adc_model (
    // Clock
    input wire logic core_clk,
    // Converter link
    input wire logic adcStart,
    input wire logic [3:0] adcChan,
    output logic [15:0] adcData
);
    logic [8:0] cnt_ff = 9'h1FF;
    logic [3:0] ch_ff = 4'h0;
    // Conversion timer restarts on every start pulse
    always @(posedge core_clk) begin
        if (adcStart) begin
            cnt_ff <= 9'h000;
            ch_ff <= adcChan;
        end else if (cnt_ff != 9'h1FF) begin
            cnt_ff <= cnt_ff + 9'h001;
        end
    end
    // Result near the sampling edge, junk otherwise: toggling while the timer runs, all ones once it stops
    assign adcData = (cnt_ff >= 9'h0BE && cnt_ff <= 9'h0D2) ? {12'h5A0, ch_ff} : {16{cnt_ff[0]}};
endmodule

// file: testbench/testbench.sv
// Register-level bench for the acquisition sequencer.
// Assumes the converter model file is compiled first.
`timescale 1ns/1ps
module testbench;
    import iaas_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [ADDR_W-1:0] avsAddr = '0;
    logic avsRd = 1'b0;
    logic avsWr = 1'b0;
    logic [31:0] avsWd = '0;
    logic [31:0] busRdata, rdData;
    logic waitReq, adcStart, irqOut;
    logic [3:0] adcChan;
    logic [15:0] adcData;
    logic startPin = 1'b1;
    logic stopPin = 1'b0;
    logic clkPin = 1'b0;
    int error_cnt = 0;
    int checks = 0;
    int cycles = 0;
    int lastStart = 0;
    int gap = 0;
    iaas_sequencer iaas_sequencer_inst (.core_clk(core_clk), .sys_rst(sys_rst),
        .avs_address(avsAddr), .avs_read(avsRd), .avs_write(avsWr), .avs_writedata(avsWd),
        .avs_byteenable(4'hF), .avs_readdata(busRdata), .avs_waitrequest(waitReq),
        .extStartPin(startPin), .extStopPin(stopPin), .extClkPin(clkPin),
        .adcStart(adcStart), .adcChan(adcChan), .adcData(adcData), .irqOut(irqOut));
    iaas_adc_model iaas_adc_model_inst (.core_clk(core_clk), .adcStart(adcStart),
        .adcChan(adcChan), .adcData(adcData));
    // Clock
    initial forever #25 core_clk = ~core_clk;
    // Cycle count, start pulse spacing and hang guard
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (adcStart === 1'b1) begin
            gap <= cycles - lastStart;
            lastStart <= cycles;
        end
        if (cycles == 40000) begin
            error_cnt++;
            print_verdict();
        end
    end
    task automatic print_verdict;
        if (error_cnt == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Avalon write: hold until waitrequest sampled low
    task automatic busW(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avsAddr <= a;
        avsWd <= d;
        avsWr <= 1'b1;
        do @(posedge core_clk); while (waitReq !== 1'b0);
        avsWr <= 1'b0;
    endtask
    // Avalon read and compare
    task automatic rdChk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        avsAddr <= a;
        avsRd <= 1'b1;
        do @(posedge core_clk); while (waitReq !== 1'b0);
        rdData = busRdata;
        avsRd <= 1'b0;
        chk(rdData, exp);
    endtask
    // Wait for the done interrupt under a bound
    task automatic waitIrq;
        int n;
        n = 0;
        while (irqOut !== 1'b1 && n < 5000) begin
            @(posedge core_clk);
            n++;
        end
        chk({31'h0, irqOut}, 32'h0000_0001);
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        rdChk(REG_CTRL, CTRL_RST);
        rdChk(REG_INTERVAL, INTERVAL_RST);
        rdChk(REG_COUNT, COUNT_RST);
        rdChk(REG_STATUS, 32'h0000_0004);
        // Software start, two paced scans of channels 0..3
        busW(REG_INTERVAL, 32'h0000_03E8);
        busW(REG_COUNT, 32'h0000_0002);
        busW(REG_IRQ_MASK, 32'h0000_0001);
        busW(REG_CTRL, 32'h0003_0001);
        waitIrq();
        chk(gap, 32'h0000_00C8);
        rdChk(REG_IRQ_STAT, 32'h0000_0009);
        for (int i = 0; i < 8; i++) begin
            rdChk(REG_DATA, 32'h0000_5A00 | (i % 4));
        end
        rdChk(REG_STATUS, 32'h0000_0004);
        busW(REG_IRQ_STAT, 32'h0000_000F);
        @(posedge core_clk);
        chk({31'h0, irqOut}, 32'h0000_0000);
        // User calibration offset applied to one sample
        busW(REG_CAL, 32'h0000_0005);
        busW(REG_COUNT, 32'h0000_0001);
        busW(REG_CTRL, 32'h0000_1001);
        waitIrq();
        busW(REG_IRQ_STAT, 32'h0000_000F);
        rdChk(REG_DATA, 32'h0000_5A05);
        // External falling start, filtered: glitch ignored, long pulse starts
        busW(REG_CTRL, 32'h0000_0245);
        startPin <= 1'b0;
        repeat (10) @(posedge core_clk);
        startPin <= 1'b1;
        repeat (300) @(posedge core_clk);
        rdChk(REG_STATUS, 32'h0000_0007);
        startPin <= 1'b0;
        waitIrq();
        rdChk(REG_DATA, 32'h0000_5A00);
        // External rising clock paces two scans, external stop ends the run
        busW(REG_IRQ_STAT, 32'h0000_000F);
        busW(REG_CTRL, 32'h0000_0029);
        repeat (2) begin
            clkPin <= 1'b1;
            repeat (5) @(posedge core_clk);
            clkPin <= 1'b0;
            repeat (250) @(posedge core_clk);
        end
        stopPin <= 1'b1;
        waitIrq();
        rdChk(REG_DATA, 32'h0000_5A00);
        rdChk(REG_DATA, 32'h0000_5A00);
        rdChk(REG_STATUS, 32'h0000_0004);
        // Software stop while armed ends at once with done only
        busW(REG_IRQ_STAT, 32'h0000_000F);
        busW(REG_CTRL, 32'h0000_0005);
        busW(REG_CTRL, 32'h0000_0006);
        rdChk(REG_IRQ_STAT, 32'h0000_0001);
        rdChk(REG_STATUS, 32'h0000_0004);
        print_verdict();
    end
endmodule
